// [design/ram_access_pkg.sv]
package ram_access_pkg;
  // access kinds, in grant priority order
  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_WRITE,
    ACC_READ,
    ACC_FETCH
  } access_kind_e;
  // fixed pipeline figures, in system clock cycles
  localparam int unsigned READ_LATENCY     = 2;
  localparam int unsigned STORE_LATENCY    = 1;
  localparam int unsigned WAIT_STATES      = 0;
  // bus port counts per ram type
  localparam int unsigned PORTS_LOCAL_SHARED  = 2;
  localparam int unsigned PORTS_DEDICATED     = 1;
  localparam int unsigned PORTS_GLOBAL_LARGE  = 3;
  localparam int unsigned PORTS_GLOBAL_SMALL  = 2;
  localparam int unsigned PORTS_MSG_CORE_ACC  = 2;
  localparam int unsigned PORTS_MSG_ACC_DMA   = 3;
  localparam int unsigned BUS_WIDTH_NARROW    = 16;
  localparam int unsigned BUS_WIDTH_WIDE      = 32;
  localparam logic [31:0] DATA_RESET          = 32'h0000_0000;
endpackage

// [design/ram_array.sv]
`timescale 1ns/100ps
module ram_array
  import ram_access_pkg::*;
#(
  parameter int unsigned ADDR_W = 9,
  parameter int unsigned DATA_W = 32
)
(
  input  wire logic              sys_clk_i,
  input  wire logic              clk_en_i,
  input  wire logic              wr_en_i,
  input  wire logic [3:0]        wr_be_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  output logic      [DATA_W-1:0] rd_data_o
);
  // the four byte lanes below assume a full word
  if (DATA_W != BUS_WIDTH_WIDE)
  begin
    $error("ram_array: data width must be 32");
  end

  logic [DATA_W-1:0] mem_ff [2**ADDR_W];

  // array runs on the system clock itself, no divider [R2]
  always_ff @(posedge sys_clk_i)
  begin
    if (clk_en_i)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wr_en_i && wr_be_i[b])
          mem_ff[addr_i][b*8 +: 8] <= wr_data_i[b*8 +: 8];
      end
      rd_data_o <= mem_ff[addr_i];
    end
  end
endmodule

// [design/onchip_ram_access_arbiter.sv]
// Notes on behaviour
// R1: no wait states; store completes in one cycle
// R2: array clocked at system clock rate
// R3: uncontended fetch or read returns after two cycles
// R4: collisions granted write, then read, then fetch
// R5: fixed port count per ram, 16/32 wide
// R6: no bursts; every access arbitrated singly
`timescale 1ns/100ps
module onchip_ram_access_arbiter
  import ram_access_pkg::*;
#(
  parameter int unsigned ADDR_W    = 9,
  parameter int unsigned NUM_PORTS = PORTS_MSG_ACC_DMA
)
(
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 clk_en_i,
  input  wire logic [NUM_PORTS-1:0] wr_req_i,
  input  wire logic [NUM_PORTS-1:0] rd_req_i,
  input  wire logic [NUM_PORTS-1:0] fetch_req_i,
  input  wire logic [NUM_PORTS-1:0] wide_i,
  input  wire logic [NUM_PORTS*ADDR_W-1:0] addr_i,
  input  wire logic [NUM_PORTS*32-1:0]     wr_data_i,
  output logic      [NUM_PORTS-1:0] grant_o,
  output logic      [NUM_PORTS-1:0] wr_done_o,
  output logic      [NUM_PORTS-1:0] rd_valid_o,
  output logic      [31:0]          rd_data_o,
  output logic      [NUM_PORTS-1:0] busy_o
);
  // port count must match one of the ram types [R5]
  if (NUM_PORTS < PORTS_DEDICATED || NUM_PORTS > PORTS_MSG_ACC_DMA)
  begin
    $error("onchip_ram_access_arbiter: port count must be 1 to 3");
  end
  if (ADDR_W < 1 || ADDR_W > 16)
  begin
    $error("onchip_ram_access_arbiter: address width out of range");
  end

  // one request per kind per port per cycle; first hit in priority order
  function automatic logic [NUM_PORTS-1:0] first_one(input logic [NUM_PORTS-1:0] v);
    logic [NUM_PORTS-1:0] r;
    r = '0;
    for (int i = NUM_PORTS-1; i >= 0; i--)
    begin
      if (v[i])
        r = '0;
      if (v[i])
        r[i] = 1'b1;
    end
    return r;
  endfunction

  function automatic int unsigned index_of(input logic [NUM_PORTS-1:0] v);
    int unsigned k;
    k = 0;
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      if (v[i])
        k = i;
    end
    return k;
  endfunction

  access_kind_e         kind;
  logic [NUM_PORTS-1:0] sel;
  int unsigned          sel_idx;
  logic [ADDR_W-1:0]    sel_addr;
  logic [31:0]          sel_data;
  logic [3:0]           sel_be;

  // write beats read beats fetch; single beat each [R4] [R6]
  always_comb
  begin
    kind = ACC_NONE;
    sel  = '0;
    if (|wr_req_i)
    begin
      kind = ACC_WRITE;
      sel  = first_one(wr_req_i);
    end
    else if (|rd_req_i)
    begin
      kind = ACC_READ;
      sel  = first_one(rd_req_i);
    end
    else if (|fetch_req_i)
    begin
      kind = ACC_FETCH;
      sel  = first_one(fetch_req_i);
    end
    sel_idx  = index_of(sel);
    sel_addr = addr_i[sel_idx*ADDR_W +: ADDR_W];
    sel_data = wr_data_i[sel_idx*BUS_WIDTH_WIDE +: BUS_WIDTH_WIDE];
    // narrow beats touch the low half only [R5]
    sel_be   = wide_i[sel_idx] ? 4'hF : 4'h3;
  end

  // losers see busy and hold their request [R4]
  assign grant_o = clk_en_i ? sel : '0;
  assign busy_o  = (wr_req_i | rd_req_i | fetch_req_i) & ~grant_o;

  logic [NUM_PORTS-1:0] rd_s1_ff;
  logic [NUM_PORTS-1:0] rd_s2_ff;
  logic [NUM_PORTS-1:0] wr_done_ff;
  logic                 wide_s1_ff;
  logic [NUM_PORTS-1:0] nxt_rd_s1;
  logic [NUM_PORTS-1:0] nxt_rd_s2;
  logic [NUM_PORTS-1:0] nxt_wr_done;
  logic                 nxt_wide_s1;
  logic [31:0]          arr_q;
  logic [31:0]          rd_data_ff;
  logic [31:0]          nxt_rd_data;

  always_comb
  begin
    nxt_rd_s1   = rd_s1_ff;
    nxt_rd_s2   = rd_s2_ff;
    nxt_wr_done = wr_done_ff;
    nxt_wide_s1 = wide_s1_ff;
    nxt_rd_data = rd_data_ff;
    if (clk_en_i)
    begin
      // read or fetch: accept, array, return -> two cycles [R3]
      nxt_rd_s1   = (kind == ACC_READ || kind == ACC_FETCH) ? sel : '0;
      nxt_wide_s1 = wide_i[sel_idx];
      nxt_rd_s2   = rd_s1_ff;
      // store acknowledged the next edge, no stall [R1]
      nxt_wr_done = (kind == ACC_WRITE) ? sel : '0;
      if (|rd_s1_ff)
        nxt_rd_data = wide_s1_ff ? arr_q : {{(BUS_WIDTH_WIDE-BUS_WIDTH_NARROW){1'b0}}, arr_q[BUS_WIDTH_NARROW-1:0]};
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_s1_ff   <= '0;
      rd_s2_ff   <= '0;
      wr_done_ff <= '0;
      wide_s1_ff <= 1'b0;
      rd_data_ff <= DATA_RESET;
    end
    else
    begin
      rd_s1_ff   <= nxt_rd_s1;
      rd_s2_ff   <= nxt_rd_s2;
      wr_done_ff <= nxt_wr_done;
      wide_s1_ff <= nxt_wide_s1;
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_valid_o = rd_s2_ff;
  assign wr_done_o  = wr_done_ff;
  assign rd_data_o  = rd_data_ff;

  ram_array #(
    .ADDR_W (ADDR_W),
    .DATA_W (32)
  ) u_array (
    .sys_clk_i (sys_clk_i),
    .clk_en_i  (clk_en_i),
    .wr_en_i   (kind == ACC_WRITE),
    .wr_be_i   (sel_be),
    .addr_i    (sel_addr),
    .wr_data_i (sel_data),
    .rd_data_o (arr_q)
  );

  property p_read_two;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (clk_en_i && (kind == ACC_READ || kind == ACC_FETCH)) ##1 clk_en_i
        |=> clk_en_i |-> (rd_valid_o == $past(sel, 2));
  endproperty
  a_read_two: assert property (p_read_two) else $error("read not returned in two cycles"); // [R3]

  property p_store_one;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (clk_en_i && kind == ACC_WRITE) |=> (wr_done_o == $past(sel));
  endproperty
  a_store_one: assert property (p_store_one) else $error("store not done in one cycle"); // [R1]

  property p_write_first;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (clk_en_i && |wr_req_i) |-> ((grant_o & wr_req_i) != '0);
  endproperty
  a_write_first: assert property (p_write_first) else $error("write lost to lower priority"); // [R4]

  property p_read_over_fetch;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (clk_en_i && !(|wr_req_i) && |rd_req_i) |-> ((grant_o & rd_req_i) != '0);
  endproperty
  a_read_over_fetch: assert property (p_read_over_fetch) else $error("fetch beat read"); // [R4]

  property p_single_grant;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $onehot0(grant_o);
  endproperty
  a_single_grant: assert property (p_single_grant) else $error("more than one grant"); // [R6]

  property p_no_wait;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (clk_en_i && (|(wr_req_i | rd_req_i | fetch_req_i))) |-> (grant_o != '0);
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("request left waiting on idle ram"); // [R1]

  // within one kind the lowest requesting port is served first
  property p_lowest_first;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (clk_en_i && !(|wr_req_i) && |rd_req_i) |-> (grant_o == (rd_req_i & (~rd_req_i + 1'b1)));
  endproperty
  a_lowest_first: assert property (p_lowest_first) else $error("read granted out of port order"); // [R4]

  // enable low must hold every returned value where it stands
  property p_frozen;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      !clk_en_i |=> ($stable(rd_valid_o) && $stable(wr_done_o) && $stable(rd_data_o));
  endproperty
  a_frozen: assert property (p_frozen) else $error("outputs moved while clock enable low"); // [R2]

  c_read:    cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) |rd_valid_o);
  c_write:   cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) |wr_done_o);
  c_collide: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) |wr_req_i && |rd_req_i && |fetch_req_i);
  c_frozen:  cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) !clk_en_i && |rd_valid_o);
endmodule

// [dv/bus_masters.sv]
`timescale 1ns/100ps
module bus_masters
  import ram_access_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        clk_en_i,
  input  wire logic [2:0]  load_i,
  input  wire logic [5:0]  kind_i,
  input  wire logic [8:0]  addr_in_i,
  input  wire logic [31:0] data_in_i,
  input  wire logic [2:0]  grant_i,
  output logic      [2:0]  wr_req_o,
  output logic      [2:0]  rd_req_o,
  output logic      [2:0]  fetch_req_o,
  output logic      [26:0] addr_o,
  output logic      [95:0] data_o
);
  logic [2:0] taken_ff;
  logic [2:0] pend_ff;
  initial {wr_req_o, rd_req_o, fetch_req_o, addr_o, data_o} = '0;
  always @(posedge sys_clk_i)
  begin
    taken_ff <= grant_i & {3{clk_en_i}};
    pend_ff  <= load_i;
  end
  // a loser holds its beat; a released address shows its inverse
  always @(negedge sys_clk_i)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (taken_ff[i])
      begin
        {wr_req_o[i], rd_req_o[i], fetch_req_o[i]} = 3'h0;
        addr_o[i*9 +: 9] = ~addr_o[i*9 +: 9];
      end
      if (pend_ff[i])
      begin
        wr_req_o[i]        = kind_i[i*2 +: 2] == ACC_WRITE;
        rd_req_o[i]        = kind_i[i*2 +: 2] == ACC_READ;
        fetch_req_o[i]     = kind_i[i*2 +: 2] == ACC_FETCH;
        addr_o[i*9 +: 9]   = addr_in_i;
        data_o[i*32 +: 32] = data_in_i;
      end
    end
  end
endmodule

// [dv/testbench.sv]
`timescale 1ns/100ps
module testbench
  import ram_access_pkg::*;
;
  logic sys_clk = 0, rst_n = 0, clk_en = 1;
  logic [2:0] wide = 3'h7, load = 3'h0, grant, busy, wr_done, rd_valid, wr_req, rd_req, fetch_req;
  logic [5:0] kind = '0;
  logic [8:0] addr_in = '0;
  logic [31:0] data_in = '0, rd_data;
  logic [26:0] addr;
  logic [95:0] wdata;
  int n_fail = 0, tests_run = 0, cyc = 0, ticks = 0;
  int cq[3][$];
  logic [31:0] eq[3][$];
  logic [31:0] mem[int];
  logic [8:0] a;
  always #50 sys_clk = ~sys_clk;
  bus_masters bm (.sys_clk_i(sys_clk), .clk_en_i(clk_en), .load_i(load), .kind_i(kind), .addr_in_i(addr_in),
    .data_in_i(data_in), .grant_i(grant), .wr_req_o(wr_req), .rd_req_o(rd_req), .fetch_req_o(fetch_req),
    .addr_o(addr), .data_o(wdata));
  onchip_ram_access_arbiter #(.ADDR_W(9), .NUM_PORTS(3)) dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
    .clk_en_i(clk_en), .wr_req_i(wr_req), .rd_req_i(rd_req), .fetch_req_i(fetch_req), .wide_i(wide),
    .addr_i(addr), .wr_data_i(wdata), .grant_o(grant), .wr_done_o(wr_done), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .busy_o(busy));
  task automatic tally_and_finish;
    if (n_fail == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  // returns on the falling edge where the request shows at the pins
  task automatic issue(logic [2:0] ld, logic [5:0] k, logic [8:0] ad, logic [31:0] d);
    @(negedge sys_clk);
    load <= ld;
    kind <= k;
    addr_in <= ad;
    data_in <= d;
    @(negedge sys_clk);
    load <= 3'h0;
  endtask
  task automatic seq3(logic [8:0] g, logic [8:0] b);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge sys_clk);
      chk("grant", g[k*3 +: 3], grant);
      chk("busy", b[k*3 +: 3], busy);
    end
  endtask
  task automatic t_width;
    issue(3'h1, {4'h0, ACC_WRITE}, 9'h05, 32'hA5A5_1234);
    issue(3'h2, {2'h0, ACC_READ, 2'h0}, 9'h05, '0);
    repeat (3) @(negedge sys_clk);
    wide <= 3'h6;
    issue(3'h1, {4'h0, ACC_WRITE}, 9'h05, 32'hFFFF_BEEF);
    issue(3'h1, {4'h0, ACC_READ}, 9'h05, '0);
    issue(3'h4, {ACC_FETCH, 4'h0}, 9'h05, '0);
    repeat (3) @(negedge sys_clk);
    wide <= 3'h7;
  endtask
  task automatic t_collide;
    issue(3'h7, {ACC_WRITE, ACC_READ, ACC_FETCH}, 9'h09, 32'h1357_9BDF);
    seq3({3'h1, 3'h2, 3'h4}, {3'h0, 3'h1, 3'h3});
    issue(3'h7, {ACC_READ, ACC_READ, ACC_READ}, 9'h05, '0);
    seq3({3'h4, 3'h2, 3'h1}, {3'h0, 3'h4, 3'h6});
    repeat (3) @(negedge sys_clk);
  endtask
  // freeze with a read in its return stage, then let a request meet a gated grant
  task automatic t_enable;
    issue(3'h1, {4'h0, ACC_READ}, 9'h09, '0);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    clk_en <= 0;
    issue(3'h2, {2'h0, ACC_READ, 2'h0}, 9'h05, '0);
    @(posedge sys_clk);
    chk("gated_grant", 3'h0, grant);
    chk("gated_busy", 3'h2, busy);
    chk("frozen_valid", 3'h1, rd_valid);
    @(negedge sys_clk);
    clk_en <= 1;
    repeat (5) @(negedge sys_clk);
    chk("left_over", 0, cq[0].size() + cq[1].size() + cq[2].size());
  endtask
  // latency counted in enabled edges from the accepting edge; a frozen pulse is taken at the next enabled edge
  always @(posedge sys_clk)
  if (rst_n && clk_en)
  begin
    cyc++;
    for (int i = 0; i < 3; i++)
    begin
      if (wr_done[i] | rd_valid[i])
      begin
        chk("latency", rd_valid[i] ? 2 : 1, cyc - cq[i].pop_front());
        if (rd_valid[i])
          chk("rd_data", eq[i][0], rd_data);
        void'(eq[i].pop_front());
      end
      if (grant[i] & clk_en)
      begin
        a = addr[i*9 +: 9];
        if (wr_req[i])
          mem[a] = wide[i] ? wdata[i*32 +: 32] : {mem[a][31:16], wdata[i*32 +: 16]};
        cq[i].push_back(cyc);
        eq[i].push_back(wide[i] ? mem[a] : {16'h0, mem[a][15:0]});
      end
    end
  end
  // ceiling near twelve times the scenarios' length; nothing follows the closing call
  always @(negedge sys_clk)
  begin
    ticks++;
    if (ticks > 500)
    begin
      n_fail++;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (3) @(negedge sys_clk);
    rst_n = 1;
    t_width;
    t_collide;
    t_enable;
    tally_and_finish;
  end
endmodule
